// ===== verilog/vcu_defines.svh
`ifndef VCU_DEFINES_SVH
`define VCU_DEFINES_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define VCU_ADDR_W 4
`define VCU_OFF_CTRL 4'h0
`define VCU_OFF_IRQ_STAT 4'h1
`define VCU_OFF_IRQ_EN 4'h2
`define VCU_OFF_IRQ_CLR 4'h3
`define VCU_OFF_SYSOPT 4'h4
// ----------------------------------------
// control register fields
// ----------------------------------------
`define VCU_BIT_ENABLE 7
`define VCU_BIT_REFSEL 6
`define VCU_BIT_FLAG 5
`define VCU_BIT_IRQEN 4
`define VCU_BIT_LIVE 3
`define VCU_BIT_PINEN 2
`define VCU_MODE_HI 1
`define VCU_MODE_LO 0
`define VCU_BIT_ROUTE 0
`define VCU_CTRL_RESET 8'h00
`define VCU_BYTE_ZERO 8'h00
`define VCU_MODE_FALL_A 2'b00
`define VCU_MODE_RISE 2'b01
`define VCU_MODE_FALL_B 2'b10
`define VCU_MODE_BOTH 2'b11
`endif

// ===== verilog/vcu_pkg.sv
package vcu_pkg;
  typedef enum logic [1:0] {
    VCU_RUN = 2'b00,
    VCU_WAIT = 2'b01,
    VCU_STOP_LIGHT = 2'b10,
    VCU_STOP_DEEP = 2'b11
  } vcu_pwr_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } vcu_bus_req_t;

  typedef struct packed {
    logic enable;
    logic refsel;
    logic irqen;
    logic pinen;
    logic [1:0] mode;
  } vcu_ctrl_t;
endpackage

// ===== verilog/vcu_edge_detect.sv
`timescale 1ns/1ns
`default_nettype none
`include "vcu_defines.svh"
module vcu_edge_detect (
  input wire logic clk_sys, // bus clock
  input wire logic reset, // sync reset, active high
  input wire logic hold, // freeze state (light stop)
  input wire logic clear, // force back to reset state
  input wire logic async_in, // raw comparator result
  input wire logic [1:0] mode, // event mode field
  output logic sync_out, // synchronised result
  output logic event_hit // one-cycle selected edge
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  wire rise = sync_q & ~prev_q;
  wire fall = ~sync_q & prev_q;
  wire hit_rise = (mode == `VCU_MODE_RISE) & rise;
  wire hit_fall = ((mode == `VCU_MODE_FALL_A) | (mode == `VCU_MODE_FALL_B)) & fall;
  wire hit_both = (mode == `VCU_MODE_BOTH) & (rise | fall);

  // meta_q is read only by sync_q [R19]
  always_ff @(posedge clk_sys) begin
    if (reset | clear) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (!hold) begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign sync_out = sync_q;
  assign event_hit = ~hold & ~clear & (hit_rise | hit_fall | hit_both); // [R15] [R19]
endmodule
`default_nettype wire

// ===== verilog/vcu_top.sv
// Overview of operation
// (R1) enabled comparator keeps comparing and detecting events through wait mode
// (R2) in wait, an enabled compare event raises an interrupt that wakes the core
// (R3) software should disable the comparator before wait if not a wake source
// (R4) comparator inactive in all stop modes, never a stop wake-up source
// (R5) deepest stop modes power down; wake-up finds all state reset
// (R6) light stop freezes registers, comparator low power, no compares
// (R7) light stop left by reset returns the block to reset state
// (R8) light stop left by interrupt resumes from the frozen state
// (R9) capture routing bit sends comparator output to timer capture channel zero
// (R10) while routed, the timer channel zero pin is unavailable externally
// (R11) software clears debug pin enable before using the result pin
// (R12) software sets bandgap buffer on when internal reference is selected
// (R13) event interrupt selectable on rising, falling or either edge
// (R14) result can drive a dedicated pin; internal reference selectable
// (R15) mode 00/10 falling, 01 rising, 11 either edge
// (R16) event flag bit 5 set on event, cleared by writing one
// (R17) live result bit 3 reads comparator output, zero while disabled
// (R18) with interrupt enable bit 4 set, flag drives interrupt request
// (R19) comparator output double synchronised, edges from previous sample
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "vcu_defines.svh"
module vcu_top (
  input wire logic clk_sys, // bus clock, 100 MHz
  input wire logic reset, // sync reset, active high
  input wire vcu_pkg::vcu_bus_req_t bus_req, // register port request
  output logic [7:0] rdata, // read data, cycle after read strobe
  input wire vcu_pkg::vcu_pwr_t pwr_mode, // processor power mode
  input wire logic cmp_raw, // asynchronous comparator result
  input wire logic timer_pin_in, // external channel zero pin level
  output logic cmp_power_on, // analog comparator powered and comparing
  output logic ref_select, // 1: internal reference on positive input
  output logic result_pin_out, // dedicated result pin level
  output logic result_pin_oe, // dedicated result pin enable
  output logic capture_in, // timer capture channel zero input
  output logic timer_pin_block, // channel zero pin taken from timer
  output logic irq // level interrupt request
);
  import vcu_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  vcu_ctrl_t ctrl_q, ctrl_d;
  logic flag_q, flag_d;
  logic route_q;
  logic irq_stat_q;
  logic irq_en_q;
  logic [7:0] rdata_q, rdata_d;
  logic cmp_power_q, ref_q, pin_out_q, pin_oe_q, cap_q, block_q, irq_q;
  logic sync_res;
  logic ev_hit;

  // ----------------------------------------
  // power modes
  // ----------------------------------------
  wire in_light_stop = (pwr_mode == VCU_STOP_LIGHT);
  wire in_deep_stop = (pwr_mode == VCU_STOP_DEEP);
  // deep stop loses everything, so model it as a held reset [R5]
  wire soft_reset = reset | in_deep_stop;
  // comparator only runs in run and wait [R1] [R4] [R6]
  wire running = ctrl_q.enable & ~in_light_stop & ~in_deep_stop;

  vcu_edge_detect u_edge (
    .clk_sys(clk_sys),
    .reset(reset),
    // analog output is junk until powered, so hold off sampling one cycle [R6] [R8] [R19]
    .hold(in_light_stop | ~cmp_power_q),
    .clear(in_deep_stop | ~ctrl_q.enable),
    .async_in(cmp_raw),
    .mode(ctrl_q.mode),
    .sync_out(sync_res),
    .event_hit(ev_hit)
  );

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  function automatic logic hit(input vcu_bus_req_t r, input logic [3:0] off);
    hit = (r.addr == off);
  endfunction

  wire wr_ctrl = bus_req.wr & hit(bus_req, `VCU_OFF_CTRL);
  wire wr_en = bus_req.wr & hit(bus_req, `VCU_OFF_IRQ_EN);
  wire wr_clr = bus_req.wr & hit(bus_req, `VCU_OFF_IRQ_CLR);
  wire wr_opt = bus_req.wr & hit(bus_req, `VCU_OFF_SYSOPT);
  // frozen registers ignore writes too (no clock in light stop) [R6]
  wire wr_ok = ~in_light_stop;
  wire new_ev = running & ev_hit;
  wire flag_clr = wr_ctrl & bus_req.wdata[`VCU_BIT_FLAG];
  wire stat_clr = wr_clr & bus_req.wdata[`VCU_BIT_FLAG];
  wire live_bit = ctrl_q.enable & sync_res; // [R17]

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl & wr_ok) begin
      ctrl_d.enable = bus_req.wdata[`VCU_BIT_ENABLE];
      ctrl_d.refsel = bus_req.wdata[`VCU_BIT_REFSEL];
      ctrl_d.irqen = bus_req.wdata[`VCU_BIT_IRQEN];
      ctrl_d.pinen = bus_req.wdata[`VCU_BIT_PINEN];
      ctrl_d.mode = bus_req.wdata[`VCU_MODE_HI:`VCU_MODE_LO];
    end
  end

  // set wins over a write-one clear in the same cycle [R16]
  assign flag_d = new_ev | (flag_q & ~(flag_clr & wr_ok));

  always_comb begin
    rdata_d = `VCU_BYTE_ZERO;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `VCU_OFF_CTRL: begin
          rdata_d[`VCU_BIT_ENABLE] = ctrl_q.enable;
          rdata_d[`VCU_BIT_REFSEL] = ctrl_q.refsel;
          rdata_d[`VCU_BIT_FLAG] = flag_q;
          rdata_d[`VCU_BIT_IRQEN] = ctrl_q.irqen;
          rdata_d[`VCU_BIT_LIVE] = live_bit; // [R17]
          rdata_d[`VCU_BIT_PINEN] = ctrl_q.pinen;
          rdata_d[`VCU_MODE_HI:`VCU_MODE_LO] = ctrl_q.mode;
        end
        `VCU_OFF_IRQ_STAT: rdata_d[`VCU_BIT_FLAG] = irq_stat_q;
        `VCU_OFF_IRQ_EN: rdata_d[`VCU_BIT_FLAG] = irq_en_q;
        `VCU_OFF_SYSOPT: rdata_d[`VCU_BIT_ROUTE] = route_q;
        default: rdata_d = `VCU_BYTE_ZERO;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // light stop holds every register; exit by interrupt resumes [R6] [R8]
  always_ff @(posedge clk_sys) begin
    if (soft_reset) begin // [R5] [R7]
      ctrl_q <= vcu_ctrl_t'(`VCU_CTRL_RESET);
      flag_q <= 1'b0;
      route_q <= 1'b0;
      irq_stat_q <= 1'b0;
      irq_en_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      flag_q <= flag_d; // [R16]
      if (wr_opt & wr_ok) route_q <= bus_req.wdata[`VCU_BIT_ROUTE];
      if (wr_en & wr_ok) irq_en_q <= bus_req.wdata[`VCU_BIT_FLAG];
      irq_stat_q <= new_ev | (irq_stat_q & ~(stat_clr & wr_ok));
    end
  end

  // outputs straight from flip-flops
  always_ff @(posedge clk_sys) begin
    if (soft_reset) begin
      rdata_q <= `VCU_BYTE_ZERO;
      cmp_power_q <= 1'b0;
      ref_q <= 1'b0;
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
      cap_q <= 1'b0;
      block_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      cmp_power_q <= running; // [R4] [R6]
      ref_q <= ctrl_q.refsel; // [R14]
      pin_oe_q <= ctrl_q.pinen & ctrl_q.enable; // [R14]
      pin_out_q <= live_bit;
      cap_q <= route_q ? live_bit : timer_pin_in; // [R9]
      block_q <= route_q; // [R10]
      // no request in stop, so no stop wake-up; flag or sticky status [R2] [R4] [R18]
      irq_q <= ~in_light_stop & ((ctrl_q.irqen & flag_d) | (irq_en_q & irq_stat_q));
    end
  end

  assign rdata = rdata_q;
  assign cmp_power_on = cmp_power_q;
  assign ref_select = ref_q;
  assign result_pin_out = pin_out_q;
  assign result_pin_oe = pin_oe_q;
  assign capture_in = cap_q;
  assign timer_pin_block = block_q;
  assign irq = irq_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_flag_sets: assert property (@(posedge clk_sys) disable iff (soft_reset) // [R16]
    new_ev |=> flag_q) else $error("event did not set flag");
  a_flag_sticky: assert property (@(posedge clk_sys) disable iff (soft_reset) // [R16]
    flag_q & ~flag_clr |=> flag_q) else $error("flag dropped without clear");
  a_live_zero: assert property (@(posedge clk_sys) disable iff (soft_reset) // [R17]
    bus_req.rd & hit(bus_req, `VCU_OFF_CTRL) & ~ctrl_q.enable |=> ~rdata[`VCU_BIT_LIVE])
    else $error("live bit set while disabled");
  a_irq_follow: assert property (@(posedge clk_sys) disable iff (soft_reset) // [R18]
    ctrl_q.irqen & flag_q & ~in_light_stop & ~flag_clr |=> irq)
    else $error("flag with enable gave no irq");
  a_stop_quiet: assert property (@(posedge clk_sys) disable iff (reset) // [R4]
    in_light_stop |=> ~irq & ~cmp_power_on) else $error("activity in stop");
  a_stop_hold: assert property (@(posedge clk_sys) disable iff (reset) // [R6]
    in_light_stop |=> ctrl_q == $past(ctrl_q) && flag_q == $past(flag_q))
    else $error("register changed in light stop");
  a_deep_reset: assert property (@(posedge clk_sys) disable iff (reset) // [R5]
    in_deep_stop |=> ctrl_q == vcu_ctrl_t'(`VCU_CTRL_RESET) && !flag_q)
    else $error("deep stop kept state");
  a_route_cap: assert property (@(posedge clk_sys) disable iff (soft_reset) // [R9]
    route_q |=> capture_in == $past(live_bit)) else $error("capture not routed");
  a_route_pin: assert property (@(posedge clk_sys) disable iff (soft_reset) // [R10]
    route_q |=> timer_pin_block) else $error("timer pin not blocked");
  a_wait_runs: assert property (@(posedge clk_sys) disable iff (soft_reset) // [R1]
    pwr_mode == VCU_WAIT & ctrl_q.enable |=> cmp_power_on) else $error("off in wait");
  c_wait_wake: cover property (@(posedge clk_sys) pwr_mode == VCU_WAIT & irq);
  c_both_edge: cover property (@(posedge clk_sys) ctrl_q.mode == `VCU_MODE_BOTH & new_ev);
  c_set_clear: cover property (@(posedge clk_sys) new_ev & flag_clr);
  c_routed: cover property (@(posedge clk_sys) route_q & live_bit);
endmodule
`default_nettype wire

// ===== testbench/vcu_cmp_model.sv
`timescale 1ns/1ns
`default_nettype none
module vcu_cmp_model (
  input wire logic clk_sys, // bus clock
  input wire logic powered, // analog part powered
  input wire logic level, // wanted comparator result
  output logic cmp_raw // comparator output
);
  logic idle_q = 1'b1;
  // unpowered output is junk: show the inverse of the last real value
  assign cmp_raw = powered ? level : idle_q;
  always @(posedge clk_sys) if (powered) idle_q <= ~level;
endmodule
`default_nettype wire

// ===== testbench/test_comparator_mode_control.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED at %0t: got %h want %h", $time, a, b); end end
module test_comparator_mode_control;
  import vcu_pkg::*;
  logic clk_sys, reset, lvl, tpin, raw, pon, rsel, pout, poe, cap, blk, irq;
  vcu_bus_req_t req;
  vcu_pwr_t pwr;
  logic [7:0] rdata;
  int checked, num_errors, cycles;
  vcu_top i_vcu_top (.clk_sys(clk_sys), .reset(reset), .bus_req(req), .rdata(rdata),
    .pwr_mode(pwr), .cmp_raw(raw), .timer_pin_in(tpin), .cmp_power_on(pon),
    .ref_select(rsel), .result_pin_out(pout), .result_pin_oe(poe), .capture_in(cap),
    .timer_pin_block(blk), .irq(irq));
  vcu_cmp_model i_vcu_cmp_model (.clk_sys(clk_sys), .powered(pon), .level(lvl),
    .cmp_raw(raw));
  // ----
  // bus tasks
  // ----
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req.wr <= 1'b1; req.addr <= a; req.wdata <= d;
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    req.rd <= 1'b1; req.addr <= a;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic done(input string s);
    $display("test %s finished, errors so far %0d", s, num_errors);
  endtask
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
  end
  // ----
  // tests
  // ----
  initial begin
    reset = 1'b1; req = '0; pwr = VCU_RUN; lvl = 1'b0; tpin = 1'b0;
    checked = 0; num_errors = 0; cycles = 0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rd(4'h0, 8'h00); rd(4'h1, 8'h00); rd(4'h7, 8'h00);
    `CHK({irq, pon, blk, poe}, 4'h0)
    done("reset");
    for (int m = 0; m < 4; m++) begin
      wr(4'h0, 8'h80 | m[7:0]); settle(6);
      wr(4'h0, 8'ha0 | m[7:0]); wr(4'h3, 8'h20);
      lvl <= 1'b1; settle(6);
      rd(4'h0, 8'h88 | m[7:0] | (m[0] ? 8'h20 : 8'h00));
      wr(4'h0, 8'ha0 | m[7:0]); lvl <= 1'b0; settle(6);
      rd(4'h0, 8'h80 | m[7:0] | (m != 1 ? 8'h20 : 8'h00));
    end
    done("modes");
    wr(4'h0, 8'hb1); wr(4'h3, 8'h20); lvl <= 1'b1; settle(6);
    `CHK(irq, 1'b1)
    rd(4'h0, 8'hb9); rd(4'h1, 8'h20);
    wr(4'h0, 8'hb1); settle(2);
    `CHK(irq, 1'b0)
    wr(4'h2, 8'h20); settle(2);
    `CHK(irq, 1'b1)
    wr(4'h3, 8'h20); wr(4'h2, 8'h00); settle(2);
    `CHK(irq, 1'b0)
    done("interrupt");
    pwr <= VCU_WAIT; lvl <= 1'b0; settle(6);
    wr(4'h0, 8'hb1); wr(4'h3, 8'h20); lvl <= 1'b1; settle(6);
    `CHK({irq, pon}, 2'b11)
    wr(4'h0, 8'h20); settle(2);
    `CHK({irq, pon}, 2'b00)
    wr(4'h0, 8'h91); settle(6);
    wr(4'h0, 8'hb1); pwr <= VCU_RUN; settle(2);
    done("wait");
    pwr <= VCU_STOP_LIGHT; settle(3);
    `CHK({irq, pon}, 2'b00)
    lvl <= 1'b0; settle(6); lvl <= 1'b1; settle(3);
    wr(4'h0, 8'h00); pwr <= VCU_RUN; settle(6);
    rd(4'h0, 8'h99);
    `CHK(irq, 1'b0)
    pwr <= VCU_STOP_LIGHT; reset <= 1'b1; settle(2);
    reset <= 1'b0; pwr <= VCU_RUN; settle(1);
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h91); wr(4'h4, 8'h01); pwr <= VCU_STOP_DEEP; settle(3);
    pwr <= VCU_RUN; settle(2);
    rd(4'h0, 8'h00); rd(4'h4, 8'h00);
    done("stop");
    // the reference buffer and debug pin are system software's job
    wr(4'h0, 8'hc4); wr(4'h4, 8'h01); settle(6);
    `CHK({rsel, poe, pout, cap, blk}, 5'h1f)
    lvl <= 1'b0; tpin <= 1'b1; settle(6);
    `CHK({pout, cap}, 2'b00)
    wr(4'h4, 8'h00); settle(3);
    `CHK({cap, blk}, 2'b10)
    lvl <= 1'b1; wr(4'h0, 8'h44); settle(3);
    rd(4'h0, 8'h64);
    `CHK({poe, pout}, 2'b00)
    done("routing");
    summarize();
  end
endmodule
`default_nettype wire
